//--- rtl/arc_top.sv
// converter result, compare, configuration and pin-control registers
//
// What this block does
// - high result holds bits 9:8, zero 8-bit
// - load results on completion unless compare fails
// - 10-bit high read locks results until low read or config write
// - completions during lock are discarded
// - 8-bit mode never locks results
// - low result holds bits 7:0 or 8-bit
// - compare bits 9:8 used only 10-bit
// - low compare byte compared in both modes
// - config bit 7 selects low power
// - config bits 6:5 divide by 1/2/4/8
// - config bit 4 selects long sample
// - config bits 3:2 select resolution
// - config bits 1:0 select input clock
// - pin-control bit n governs channel n pin
// - set bit tristates, zeroes input, drops pullup
// - compare less-than, or greater-or-equal when set
// - round raw result to 10 or 8 bits
`include "arc_defines.svh"

module arc_top
    import arc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter core
    input wire logic conv_done,
    input wire logic [10:0] conv_raw,
    output logic low_power_select,
    output logic [1:0] clock_divide_select,
    output logic long_sample_select,
    output logic [1:0] conv_mode,
    output logic [1:0] input_clock_select,
    output logic converter_clock,
    // clock sources, asynchronous
    input wire logic alternate_clock,
    input wire logic internal_async_clock,
    // port pin logic
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe,
    input wire logic [7:0] port_pullup,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pullup,
    output logic [7:0] port_in
);

    // ****************************************************
    // register state
    // ****************************************************
    logic [7:0] converter_config;
    logic [7:0] compare_value_high;
    logic [7:0] compare_value_low;
    logic [7:0] analog_pin_disable_lo;
    logic [1:0] compare_ctrl;
    logic [7:0] conv_result_high;
    logic [7:0] conv_result_low;
    logic result_lock;

    logic apb_done;
    logic wr_done;
    logic rd_done;
    logic mode_10;
    logic compare_enable;
    logic compare_greater_select;

    assign apb_done = psel & penable & pready;
    assign wr_done = apb_done & pwrite;
    assign rd_done = apb_done & ~pwrite;
    assign mode_10 = converter_config[`ARC_CFG_MODE_HI:`ARC_CFG_MODE_LO]
        == ARC_MODE_10BIT;
    assign compare_enable = compare_ctrl[`ARC_CTRL_CMP_EN];
    assign compare_greater_select = compare_ctrl[`ARC_CTRL_CMP_GT];

    // ****************************************************
    // apb handshake
    // ****************************************************
    // one wait state so prdata and pslverr come from flops
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    logic [31:0] next_prdata;
    logic next_pslverr;

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        unique case (paddr)
            `ARC_OFF_RESULT_HIGH: begin
                // 8-bit mode reads zero above the low byte
                next_prdata[7:0] = mode_10 ? conv_result_high
                    : 8'h00;
            end
            `ARC_OFF_RESULT_LOW: begin
                next_prdata[7:0] = conv_result_low;
            end
            `ARC_OFF_CMP_HIGH: begin
                next_prdata[7:0] = compare_value_high;
            end
            `ARC_OFF_CMP_LOW: begin
                next_prdata[7:0] = compare_value_low;
            end
            `ARC_OFF_CONFIG: begin
                next_prdata[7:0] = converter_config;
            end
            `ARC_OFF_PIN_DISABLE: begin
                next_prdata[7:0] = analog_pin_disable_lo;
            end
            `ARC_OFF_CMP_CTRL: begin
                next_prdata[1:0] = compare_ctrl;
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // ****************************************************
    // software registers
    // ****************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            converter_config <= `ARC_RST_CONFIG;
        end else if (wr_done && paddr == `ARC_OFF_CONFIG) begin
            // reserved mode codes are stored as written
            converter_config <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            compare_value_high <= `ARC_RST_CMP;
            compare_value_low <= `ARC_RST_CMP;
        end else if (wr_done) begin
            if (paddr == `ARC_OFF_CMP_HIGH) begin
                compare_value_high <= pwdata[7:0];
            end
            if (paddr == `ARC_OFF_CMP_LOW) begin
                compare_value_low <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            analog_pin_disable_lo <= `ARC_RST_PIN_DISABLE;
        end else if (wr_done && paddr == `ARC_OFF_PIN_DISABLE) begin
            analog_pin_disable_lo <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            compare_ctrl <= `ARC_RST_CTRL;
        end else if (wr_done && paddr == `ARC_OFF_CMP_CTRL) begin
            compare_ctrl <= pwdata[1:0];
        end
    end

    // ****************************************************
    // configuration to the converter core
    // ****************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            low_power_select <= 1'b0;
            clock_divide_select <= 2'h0;
            long_sample_select <= 1'b0;
            conv_mode <= 2'h0;
            input_clock_select <= 2'h0;
        end else begin
            low_power_select <=
                converter_config[`ARC_CFG_LOW_POWER];
            clock_divide_select <=
                converter_config[`ARC_CFG_DIV_HI:`ARC_CFG_DIV_LO];
            long_sample_select <=
                converter_config[`ARC_CFG_LONG_SAMPLE];
            conv_mode <=
                converter_config[`ARC_CFG_MODE_HI:`ARC_CFG_MODE_LO];
            input_clock_select <=
                converter_config[`ARC_CFG_CLK_HI:`ARC_CFG_CLK_LO];
        end
    end

    // ****************************************************
    // converter clock select and divide
    // ****************************************************
    logic [1:0] alt_sync;
    logic [1:0] async_sync;
    logic alt_last;
    logic async_last;
    logic bus_half;
    logic src_tick;
    logic [2:0] div_count;
    logic [2:0] div_limit;

    // slow sources become enables; they must run well below sys_clk/2
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            alt_sync <= 2'h0;
            async_sync <= 2'h0;
            alt_last <= 1'b0;
            async_last <= 1'b0;
            bus_half <= 1'b0;
        end else begin
            alt_sync <= {alt_sync[0], alternate_clock};
            async_sync <= {async_sync[0], internal_async_clock};
            alt_last <= alt_sync[1];
            async_last <= async_sync[1];
            bus_half <= ~bus_half;
        end
    end

    always_comb begin
        unique case (arc_clk_src_t'(input_clock_select))
            ARC_SRC_BUS: src_tick = 1'b1;
            ARC_SRC_BUS_HALF: src_tick = bus_half;
            ARC_SRC_ALT: src_tick = alt_sync[1] & ~alt_last;
            ARC_SRC_ASYNC: src_tick = async_sync[1] & ~async_last;
        endcase
    end

    assign div_limit = 3'((4'h1 << clock_divide_select) - 4'h1);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div_count <= 3'h0;
            converter_clock <= 1'b0;
        end else begin
            converter_clock <= src_tick && div_count >= div_limit;
            if (src_tick) begin
                div_count <= (div_count >= div_limit) ? 3'h0
                    : div_count + 3'h1;
            end
        end
    end

    // ****************************************************
    // rounding and compare
    // ****************************************************
    function automatic logic [9:0] arc_round10(input logic [10:0] raw);
        logic [10:0] sum;
        sum = {1'b0, raw[10:1]} + {10'h000, raw[0]};
        arc_round10 = sum[10] ? 10'h3ff : sum[9:0];
    endfunction

    function automatic logic [7:0] arc_round8(input logic [8:0] raw);
        logic [8:0] sum;
        sum = {1'b0, raw[8:1]} + {8'h00, raw[0]};
        arc_round8 = sum[8] ? 8'hff : sum[7:0];
    endfunction

    logic [9:0] rounded;
    logic [9:0] cmp_value;
    logic cmp_met;
    logic load_ok;

    always_comb begin
        if (mode_10) begin
            rounded = arc_round10(conv_raw);
            cmp_value = {compare_value_high[1:0],
                compare_value_low};
        end else begin
            rounded = {2'h0, arc_round8(conv_raw[8:0])};
            cmp_value = {2'h0, compare_value_low};
        end
    end

    assign cmp_met = compare_greater_select ? (rounded >= cmp_value)
        : (rounded < cmp_value);

    // lock only matters in 10-bit mode
    assign load_ok = conv_done && !(mode_10 && result_lock)
        && (!compare_enable || cmp_met);

    // ****************************************************
    // result registers and interlock
    // ****************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            conv_result_high <= `ARC_RST_RESULT;
            conv_result_low <= `ARC_RST_RESULT;
        end else if (load_ok) begin
            conv_result_high <= {6'h00, rounded[9:8]};
            conv_result_low <= rounded[7:0];
        end
    end

    // a completion in the same cycle as the low read is still dropped
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            result_lock <= 1'b0;
        end else if (rd_done && paddr == `ARC_OFF_RESULT_LOW) begin
            result_lock <= 1'b0;
        end else if (rd_done && paddr == `ARC_OFF_RESULT_HIGH
            && mode_10) begin
            result_lock <= 1'b1;
        end else if (wr_done && paddr == `ARC_OFF_CONFIG) begin
            // results are stale after a reconfigure anyway
            result_lock <= 1'b0;
        end
    end

    // ****************************************************
    // pin control per channel
    // ****************************************************
    logic [7:0] pad_sync0;
    logic [7:0] pad_sync1;

    generate
        for (genvar ch = 0; ch < `ARC_CHANNELS; ch++) begin : g_pin
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    pad_sync0[ch] <= 1'b0;
                    pad_sync1[ch] <= 1'b0;
                    pad_out[ch] <= 1'b0;
                    pad_oe[ch] <= 1'b0;
                    pad_pullup[ch] <= 1'b0;
                    port_in[ch] <= 1'b0;
                end else begin
                    pad_sync0[ch] <= pad_in[ch];
                    pad_sync1[ch] <= pad_sync0[ch];
                    if (analog_pin_disable_lo[ch]) begin
                        pad_out[ch] <= 1'b0;
                        pad_oe[ch] <= 1'b0;
                        pad_pullup[ch] <= 1'b0;
                        port_in[ch] <= 1'b0;
                    end else begin
                        pad_out[ch] <= port_out[ch];
                        pad_oe[ch] <= port_oe[ch];
                        pad_pullup[ch] <= port_pullup[ch];
                        port_in[ch] <= pad_sync1[ch];
                    end
                end
            end
        end
    endgenerate

endmodule

//--- inc/arc_defines.svh
// register offsets, field positions, reset values and counts for arc
`ifndef ARC_DEFINES_SVH
`define ARC_DEFINES_SVH

// ****************************************************
// register byte offsets
// ****************************************************
`define ARC_OFF_RESULT_HIGH 8'h00
`define ARC_OFF_RESULT_LOW 8'h04
`define ARC_OFF_CMP_HIGH 8'h08
`define ARC_OFF_CMP_LOW 8'h0c
`define ARC_OFF_CONFIG 8'h10
`define ARC_OFF_PIN_DISABLE 8'h14
`define ARC_OFF_CMP_CTRL 8'h18

// ****************************************************
// converter_config fields
// ****************************************************
`define ARC_CFG_LOW_POWER 7
`define ARC_CFG_DIV_HI 6
`define ARC_CFG_DIV_LO 5
`define ARC_CFG_LONG_SAMPLE 4
`define ARC_CFG_MODE_HI 3
`define ARC_CFG_MODE_LO 2
`define ARC_CFG_CLK_HI 1
`define ARC_CFG_CLK_LO 0

// ****************************************************
// compare control fields
// ****************************************************
`define ARC_CTRL_CMP_EN 0
`define ARC_CTRL_CMP_GT 1

// ****************************************************
// reset values
// ****************************************************
`define ARC_RST_CONFIG 8'h00
`define ARC_RST_CMP 8'h00
`define ARC_RST_PIN_DISABLE 8'h00
`define ARC_RST_CTRL 2'h0
`define ARC_RST_RESULT 8'h00

// ****************************************************
// sizes
// ****************************************************
`define ARC_CHANNELS 8
`define ARC_RAW_W 11

`endif

//--- inc/arc_pkg.sv
// types shared by the arc result, compare and config block
package arc_pkg;
    typedef enum logic [1:0] {
        ARC_MODE_8BIT,
        ARC_MODE_RSVD1,
        ARC_MODE_10BIT,
        ARC_MODE_RSVD3
    } arc_mode_t;

    typedef enum logic [1:0] {
        ARC_SRC_BUS,
        ARC_SRC_BUS_HALF,
        ARC_SRC_ALT,
        ARC_SRC_ASYNC
    } arc_clk_src_t;
endpackage

//--- dv/arc_top_chk.sv
// assertion checker for the arc register block, bound to arc_top
module arc_top_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // converter settings
    input wire logic low_power_select,
    input wire logic [1:0] clock_divide_select,
    input wire logic long_sample_select,
    input wire logic [1:0] conv_mode,
    input wire logic [1:0] input_clock_select
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    logic acc;
    logic cfg_wr;
    logic [7:0] wd;
    assign acc = psel && penable && pready;
    assign cfg_wr = acc && pwrite && paddr == 8'h10;
    // config byte kept until the settings have passed both flop stages
    always_ff @(posedge sys_clk) begin
        if (cfg_wr) begin
            wd <= pwdata[7:0];
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    wait_state_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    unmapped_err_a: assert property (acc && paddr[1:0] == 2'b00
        |-> pslverr == (paddr > 8'h18))
        else $error("pslverr does not match address decode");
    upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    high_zero_a: assert property (
        acc && !pwrite && paddr == 8'h00 && conv_mode == 2'b00
        |-> prdata == 32'h0)
        else $error("high result not zero in 8-bit mode");
    power_sample_a: assert property (cfg_wr |-> ##2
        low_power_select == wd[7] && long_sample_select == wd[4])
        else $error("power or sample select wrong after write");
    divide_sel_a: assert property (
        cfg_wr |-> ##2 clock_divide_select == wd[6:5])
        else $error("clock divide select wrong after write");
    mode_sel_a: assert property (cfg_wr |-> ##2 conv_mode == wd[3:2])
        else $error("conversion mode wrong after write");
    clock_sel_a: assert property (
        cfg_wr |-> ##2 input_clock_select == wd[1:0])
        else $error("input clock select wrong after write");
endmodule

bind arc_top arc_top_chk u_chk (.sys_clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .low_power_select,
    .clock_divide_select, .long_sample_select, .conv_mode,
    .input_clock_select);

//--- dv/arc_core_model.sv
// behavioural model of the converter core feeding raw results
module arc_core_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // request from the bench
    input wire logic start,
    input wire logic [10:0] raw,
    // to the block
    output logic conv_done,
    output logic [10:0] conv_raw,
    output logic alternate_clock,
    output logic internal_async_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [3:0] cnt;
    logic [10:0] held;
    initial begin
        // edges kept off the sys_clk edge so tick counts are exact
        alternate_clock = 1'b0;
        #2;
        forever #20 alternate_clock = ~alternate_clock;
    end
    initial begin
        internal_async_clock = 1'b0;
        forever #13 internal_async_clock = ~internal_async_clock;
    end
    // raw bus is only meaningful with the done pulse, so scramble it
    always_ff @(posedge sys_clk) begin
        conv_done <= 1'b0;
        conv_raw <= ~conv_raw;
        if (reset) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            conv_raw <= 11'h0;
        end else if (start) begin
            busy <= 1'b1;
            cnt <= 4'h5;
            held <= raw;
        end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (busy) begin
            busy <= 1'b0;
            conv_done <= 1'b1;
            conv_raw <= held;
        end
    end
endmodule

//--- dv/arc_top_tb.sv
// self-checking bench for arc_top with a converter core model
module arc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset, psel, penable, pwrite, start, conv_done;
    logic pready, pslverr, low_power_select, long_sample_select;
    logic converter_clock, alternate_clock, internal_async_clock;
    logic [1:0] clock_divide_select, conv_mode, input_clock_select;
    logic [7:0] paddr, port_out, port_oe, port_pullup, pad_in;
    logic [7:0] pad_out, pad_oe, pad_pullup, port_in;
    logic [10:0] conv_raw, raw;
    logic [31:0] pwdata, prdata;
    int n_mismatch = 0;
    int comparisons = 0;
    arc_top u_dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .conv_done, .conv_raw,
        .low_power_select, .clock_divide_select, .long_sample_select,
        .conv_mode, .input_clock_select, .converter_clock,
        .alternate_clock, .internal_async_clock, .port_out, .port_oe,
        .port_pullup, .pad_in, .pad_out, .pad_oe, .pad_pullup, .port_in);
    arc_core_model u_core (.sys_clk, .reset, .start, .raw, .conv_done,
        .conv_raw, .alternate_clock, .internal_async_clock);
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] x,
        input logic [31:0] y);
        comparisons++;
        if (y !== x) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk($sformatf("read %h", a), x, r);
    endtask
    // completes when the block has sampled the done pulse
    task automatic conv(input logic [10:0] v);
        start <= 1'b1;
        raw <= v;
        @(posedge sys_clk);
        start <= 1'b0;
        while (conv_done !== 1'b1) begin
            @(posedge sys_clk);
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        for (int i = 2; i < 7; i++) rd(8'(4 * i), 32'h0);
        apb(1'b1, 8'h1c, 32'hff, r, e);
        chk("unmapped err", 32'h1, 32'(e));
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk("unmapped data", 32'h0, r);
        wr(8'h04, 8'hff);
        rd(8'h04, 32'h0);
    endtask
    task automatic t_cfg;
        int n;
        wr(8'h10, 8'hf9);
        rd(8'h10, 32'hf9);
        chk("cfg pins", 32'hf9, {low_power_select,
            clock_divide_select, long_sample_select, conv_mode,
            input_clock_select});
        // alternate clock runs at one tick per five bus cycles
        for (int i = 0; i < 6; i++) begin
            wr(8'h10, i < 4 ? {1'b0, 2'(i), 5'h0} : 8'(i - 3));
            n = 0;
            repeat (2) @(posedge sys_clk);
            repeat (40) begin
                @(posedge sys_clk);
                n += converter_clock;
            end
            chk("clock ticks", i < 4 ? 40 >> i : (i == 4 ? 20 : 8), n);
        end
    endtask
    task automatic t_ten;
        wr(8'h10, 8'h08);
        conv(11'h2ab);
        rd(8'h00, 32'h1);
        conv(11'h7ff);
        rd(8'h04, 32'h56);
        conv(11'h7ff);
        rd(8'h00, 32'h3);
        rd(8'h04, 32'hff);
    endtask
    task automatic t_eight;
        wr(8'h10, 8'h00);
        conv(11'h0a5);
        rd(8'h00, 32'h0);
        conv(11'h03f);
        rd(8'h04, 32'h20);
    endtask
    task automatic t_cmp;
        wr(8'h08, 8'h01);
        wr(8'h0c, 8'h40);
        wr(8'h18, 8'h01);
        conv(11'h09f);
        rd(8'h04, 32'h20);
        conv(11'h03d);
        rd(8'h04, 32'h1f);
        wr(8'h18, 8'h03);
        conv(11'h01f);
        rd(8'h04, 32'h1f);
        conv(11'h0a1);
        rd(8'h04, 32'h51);
        wr(8'h10, 8'h08);
        conv(11'h2a0);
        rd(8'h04, 32'h50);
        conv(11'h27e);
        rd(8'h04, 32'h50);
    endtask
    task automatic t_pins;
        port_out <= 8'ha5;
        port_oe <= 8'hff;
        port_pullup <= 8'h3c;
        pad_in <= 8'h96;
        wr(8'h14, 8'h0f);
        repeat (4) @(posedge sys_clk);
        rd(8'h14, 32'h0f);
        chk("pad pins", 32'ha0f03090,
            {pad_out, pad_oe, pad_pullup, port_in});
    endtask
    task automatic results;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
    initial begin
        {reset, psel, penable, pwrite, start} = 5'h10;
        {paddr, pwdata, raw} = 51'h0;
        {port_out, port_oe, port_pullup, pad_in} = 32'h0;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_cfg();
        t_ten();
        t_eight();
        t_cmp();
        t_pins();
        results();
    end
endmodule
